// file: logic/tspt_defines.svh
// Constants for the slot protection and trail termination block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TSPT_DEFINES_SVH
`define TSPT_DEFINES_SVH

// Register byte offsets on the plain register port.
`define TSPT_REG_STATUS 8'h00
`define TSPT_REG_MASK 8'h04
`define TSPT_REG_STATE 8'h08
`define TSPT_REG_MAP 8'h0C

// Sticky status and mask bit positions.
`define TSPT_ST_SWITCH 0
`define TSPT_ST_FAULT_A 1
`define TSPT_ST_FAULT_B 2
`define TSPT_ST_FAULT_ACT 3
`define TSPT_ST_W 4

// State register fields: selected side, three causes, three faults.
`define TSPT_PSS_SEL 0
`define TSPT_PSS_CAUSE 1
`define TSPT_PSS_FAULT 4

// Tunnel map register: valid flag in the top bit, entries from bit zero.
`define TSPT_MAP_VALID 31
`define TSPT_MAP_RESET 32'h0000_0000

// Timing of the server fail fault integrator.
`define TSPT_CLK_HZ 10000000
`define TSPT_FAULT_SET_MS 2500
`define TSPT_FAULT_CLR_MS 10000
`define TSPT_FAULT_TOL_MS 500
`define TSPT_FAULT_SET_CYC (`TSPT_FAULT_SET_MS * (`TSPT_CLK_HZ / 1000))
`define TSPT_FAULT_CLR_CYC (`TSPT_FAULT_CLR_MS * (`TSPT_CLK_HZ / 1000))

`endif

// file: logic/tspt_fault_timer.sv
// Server fail fault integrator for one trail termination sink.
// Assumes a cause input that is already synchronous to sys_clk_in.
`timescale 1ns/100ps
`include "tspt_defines.svh"
module tspt_fault_timer #(
	parameter int unsigned SET_CYC = `TSPT_FAULT_SET_CYC,
	parameter int unsigned CLR_CYC = `TSPT_FAULT_CLR_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic cause_in,
	output logic fault_out
);
	import tspt_pkg::*;

	// Wide enough for the longer of the two persistence windows.
	localparam int CNT_W = $clog2((SET_CYC > CLR_CYC ? SET_CYC : CLR_CYC) + 1);

	logic [CNT_W-1:0] cnt_q, cnt_d; // Cycles the cause has differed from the fault.
	logic fault_q, fault_d; // Integrated fault.
	logic [CNT_W-1:0] limit; // Window for the pending change.

	// The count restarts whenever the cause agrees with the fault, so only an
	// unbroken run of the opposite level can flip it.
	always_comb begin
		cnt_d = cnt_q;
		fault_d = fault_q;
		limit = fault_q ? CNT_W'(CLR_CYC - 1) : CNT_W'(SET_CYC - 1);
		if (ce_in) begin
			if (cause_in == fault_q) begin
				cnt_d = '0;
			end else if (cnt_q == limit) begin
				fault_d = cause_in; // RULE18 RULE19
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q + CNT_W'(1);
			end
		end
	end

	// Registers only; the clock enable is already folded into the next values.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cnt_q <= '0;
			fault_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			fault_q <= fault_d;
		end
	end

	assign fault_out = fault_q;

	// Fault may only rise after the full set window with the cause held.
	AST_FAULT_RISE: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE18
		$rose(fault_q) |-> $past(cause_in) && $past(cnt_q) == CNT_W'(SET_CYC - 1))
		else $error("Fault rose without a full set window.");
	// Fault may only fall after the full clear window with the cause low.
	AST_FAULT_FALL: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE19
		$fell(fault_q) && !$past(rst_in) |-> !$past(cause_in) && $past(cnt_q) == CNT_W'(CLR_CYC - 1))
		else $error("Fault fell without a full clear window.");
	COV_FAULT_RISE: cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(fault_q));
endmodule

// file: logic/tspt_pkg.sv
// Types shared by the slot protection and trail termination block.
// Assumes the defines header sits beside it.
`include "tspt_defines.svh"
package tspt_pkg;
	// Which received physical interface supplies the active channel.
	typedef enum logic {TSPT_SEL_A, TSPT_SEL_B} tspt_sel_t;
	// One register word.
	typedef logic [31:0] tspt_word_t;
	// Register byte address.
	typedef logic [7:0] tspt_addr_t;
endpackage

// file: logic/tspt_top.sv
// Slot layer 1+1 protection switch, tunnel switch and trail terminations.
// Assumes channel pins come from other clock domains and are synchronised here;
// register port signals are synchronous to sys_clk_in.
// Function
// RULE1 - One plus one protection over two slot channels.
// RULE2 - Transmit channel duplicated onto both paths.
// RULE3 - Each receive path's fail drives switch state.
// RULE4 - Either healthy path may be active.
// RULE5 - Switch state names interface A or B.
// RULE6 - Active fails, other healthy: switch over.
// RULE7 - Both failing: keep current active channel.
// RULE8 - Only active channel signals routed onward.
// RULE9 - Switch state always shown on management output.
// RULE10 - Tunnel transmit passes tunnel source functions.
// RULE11 - Tunnel receive recovers individual tunnelled channels.
// RULE12 - Tunnel switching follows management map table.
// RULE13 - Slot trail termination supervises both directions.
// RULE14 - Protection trail termination supervises both directions.
// RULE15 - Terminations pass data; sources copy fail.
// RULE16 - Sink trail fail action follows server fail.
// RULE17 - Sink fail cause reported on management output.
// RULE18 - Fault sets after 2.5 s steady cause.
// RULE19 - Fault clears after 10 s steady clear.
`timescale 1ns/100ps
`include "tspt_defines.svh"
module tspt_top #(
	parameter int DATA_W = 8,
	parameter int TUN_N = 4,
	parameter int unsigned FAULT_SET_CYC = `TSPT_FAULT_SET_CYC,
	parameter int unsigned FAULT_CLR_CYC = `TSPT_FAULT_CLR_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Register port.
	input wire tspt_pkg::tspt_addr_t reg_addr_in,
	input wire tspt_pkg::tspt_word_t reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output tspt_pkg::tspt_word_t reg_rdata_out,
	output logic irq_out,
	// Protected transmit channel from the connection function.
	input wire logic [DATA_W-1:0] tx_data_in,
	input wire logic tx_ck_in,
	input wire logic tx_fs_in,
	input wire logic tx_trail_fail_in,
	// Duplicated transmit paths towards interfaces A and B.
	output logic [DATA_W-1:0] path_a_data_out,
	output logic path_a_ck_out,
	output logic path_a_fs_out,
	output logic path_a_ssf_out,
	output logic [DATA_W-1:0] path_b_data_out,
	output logic path_b_ck_out,
	output logic path_b_fs_out,
	output logic path_b_ssf_out,
	// Received channels from interfaces A and B.
	input wire logic [DATA_W-1:0] rx_a_data_in,
	input wire logic rx_a_ck_in,
	input wire logic rx_a_fs_in,
	input wire logic rx_a_server_signal_fail_in,
	input wire logic [DATA_W-1:0] rx_b_data_in,
	input wire logic rx_b_ck_in,
	input wire logic rx_b_fs_in,
	input wire logic rx_b_server_signal_fail_in,
	// Active channel after the slot trail termination sink.
	output logic [DATA_W-1:0] rx_data_out,
	output logic rx_ck_out,
	output logic rx_fs_out,
	output logic adapted_trail_fail_out,
	output logic sink_fail_cause_report_out,
	output logic sink_fail_fault_out,
	// Management view of the two protected sinks and the switch.
	output logic protected_sink_fail_cause_report_a_out,
	output logic protected_sink_fail_cause_report_b_out,
	output logic protection_switch_state_report_out,
	// Tunnel transmit.
	input wire logic [DATA_W-1:0] tun_tx_data_in,
	input wire logic tun_tx_ck_in,
	input wire logic tun_tx_fs_in,
	input wire logic tun_tx_trail_fail_in,
	output logic [DATA_W-1:0] tun_tx_data_out,
	output logic tun_tx_ck_out,
	output logic tun_tx_fs_out,
	output logic tun_tx_ssf_out,
	// Tunnel receive: TUN_N packed sub-channels in, mapped sub-channels out.
	input wire logic [TUN_N*DATA_W-1:0] tun_rx_data_in,
	input wire logic tun_rx_ck_in,
	input wire logic tun_rx_fs_in,
	input wire logic tun_rx_server_signal_fail_in,
	output logic [TUN_N*DATA_W-1:0] tun_ch_data_out,
	output logic tun_ch_ck_out,
	output logic tun_ch_fs_out,
	output logic tun_ch_ssf_out
);
	import tspt_pkg::*;

	localparam int CH_W = DATA_W + 3; // Data, clock, frame start, fail.
	localparam int TUN_W = TUN_N * DATA_W + 3;
	localparam int IN_W = 4 * CH_W + TUN_W;
	localparam int IDX_W = $clog2(TUN_N); // TUN_N must be at least two.

	// Two-stage synchroniser for every channel pin that arrives from outside.
	logic [IN_W-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
	always_comb begin
		sync1_d = {tx_data_in, tx_ck_in, tx_fs_in, tx_trail_fail_in,
			rx_a_data_in, rx_a_ck_in, rx_a_fs_in, rx_a_server_signal_fail_in,
			rx_b_data_in, rx_b_ck_in, rx_b_fs_in, rx_b_server_signal_fail_in,
			tun_tx_data_in, tun_tx_ck_in, tun_tx_fs_in, tun_tx_trail_fail_in,
			tun_rx_data_in, tun_rx_ck_in, tun_rx_fs_in, tun_rx_server_signal_fail_in};
		sync2_d = sync1_q; // The first stage feeds only the second.
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else if (ce_in) begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// Synchronised channel bundles, each {data, ck, fs, fail}.
	logic [CH_W-1:0] tx_s, rxa_s, rxb_s, ttx_s;
	logic [TUN_W-1:0] trx_s;
	assign {tx_s, rxa_s, rxb_s, ttx_s, trx_s} = sync2_q;

	// Fail flags after the protected sinks and the empty adaptation sinks.
	// The adaptation copies the sink's trail fail action straight to the
	// switch, so both stages reduce to the synchronised fail bit.
	logic a_ssf, b_ssf;
	assign a_ssf = rxa_s[0]; // RULE3 RULE14 RULE16
	assign b_ssf = rxb_s[0]; // RULE3 RULE14 RULE16

	// Protection switch state; starts on interface A after reset.
	tspt_sel_t sel_q, sel_d;
	logic act_ssf;
	always_comb begin
		act_ssf = (sel_q == TSPT_SEL_A) ? a_ssf : b_ssf;
		sel_d = sel_q;
		case (sel_q)
			// A healthy active channel is never left, so either side may serve.
			TSPT_SEL_A: begin
				if (a_ssf && !b_ssf) begin
					sel_d = TSPT_SEL_B; // RULE6 RULE4
				end
			end
			TSPT_SEL_B: begin
				if (b_ssf && !a_ssf) begin
					sel_d = TSPT_SEL_A; // RULE6 RULE4
				end
			end
			default: begin
				sel_d = TSPT_SEL_A;
			end
		endcase
		// With both sides failing neither branch fires and the choice holds. RULE7
	end

	// Receive datapath: the active bundle only, through the slot sink.
	logic [CH_W-1:0] act_s;
	logic [CH_W-1:0] rx_q, rx_d;
	logic cause_a_q, cause_b_q, cause_act_q, cause_a_d, cause_b_d, cause_act_d;
	logic pss_q, pss_d;
	always_comb begin
		act_s = (sel_q == TSPT_SEL_A) ? rxa_s : rxb_s; // RULE8 RULE1
		rx_d = act_s; // RULE13 RULE15 RULE16
		cause_a_d = a_ssf; // RULE17
		cause_b_d = b_ssf; // RULE17
		cause_act_d = act_s[0]; // RULE17
		pss_d = (sel_d == TSPT_SEL_B); // RULE5 RULE9
	end

	// Transmit: slot source copies the trail fail to its server fail, then the
	// protected channel is split onto two protection source chains.
	logic [CH_W-1:0] pa_q, pa_d, pb_q, pb_d, ttx_q, ttx_d;
	always_comb begin
		pa_d = tx_s; // RULE2 RULE13 RULE14 RULE15
		pb_d = tx_s; // RULE2 RULE14 RULE15
		ttx_d = ttx_s; // RULE10 RULE15
	end

	// Tunnel map table: one sub-channel index per output lane plus a valid flag.
	logic [31:0] map_q, map_d;
	logic [TUN_N*DATA_W-1:0] tun_q, tun_d;
	logic tun_ck_q, tun_ck_d, tun_fs_q, tun_fs_d, tun_ssf_q, tun_ssf_d;
	logic [TUN_N*DATA_W-1:0] trx_data;
	logic [IDX_W-1:0] idx;
	assign trx_data = trx_s[TUN_W-1:3];
	always_comb begin
		idx = '0;
		tun_d = '0;
		// Without a valid map the lanes carry idle and signal fail, since an
		// unprogrammed table would otherwise scramble the channels.
		if (map_q[`TSPT_MAP_VALID]) begin
			for (int i = 0; i < TUN_N; i++) begin
				idx = map_q[i*IDX_W +: IDX_W];
				tun_d[i*DATA_W +: DATA_W] = trx_data[idx*DATA_W +: DATA_W]; // RULE11 RULE12
			end
		end
		tun_ck_d = trx_s[2];
		tun_fs_d = trx_s[1];
		tun_ssf_d = trx_s[0] || !map_q[`TSPT_MAP_VALID]; // RULE12
	end

	// Fault integrators for the two protected sinks and the slot sink.
	logic fault_a, fault_b, fault_act;
	tspt_fault_timer #(.SET_CYC(FAULT_SET_CYC), .CLR_CYC(FAULT_CLR_CYC)) u_fault_a (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.cause_in(cause_a_q), .fault_out(fault_a));
	tspt_fault_timer #(.SET_CYC(FAULT_SET_CYC), .CLR_CYC(FAULT_CLR_CYC)) u_fault_b (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.cause_in(cause_b_q), .fault_out(fault_b));
	tspt_fault_timer #(.SET_CYC(FAULT_SET_CYC), .CLR_CYC(FAULT_CLR_CYC)) u_fault_act (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.cause_in(cause_act_q), .fault_out(fault_act));

	// Register port, sticky status and interrupt.
	logic [`TSPT_ST_W-1:0] st_q, st_d, mask_q, mask_d, ev;
	logic [2:0] fprev_q, fprev_d;
	logic [31:0] rdata_q, rdata_d, state_word;
	logic irq_q, irq_d, fault_act_q, fault_act_d;
	always_comb begin
		state_word = '0;
		state_word[`TSPT_PSS_SEL] = pss_q;
		state_word[`TSPT_PSS_CAUSE +: 3] = {cause_act_q, cause_b_q, cause_a_q};
		state_word[`TSPT_PSS_FAULT +: 3] = {fault_act, fault_b, fault_a};
		fprev_d = {fault_act, fault_b, fault_a};
		ev = '0;
		ev[`TSPT_ST_SWITCH] = (sel_d != sel_q);
		ev[`TSPT_ST_FAULT_A] = fault_a ^ fprev_q[0];
		ev[`TSPT_ST_FAULT_B] = fault_b ^ fprev_q[1];
		ev[`TSPT_ST_FAULT_ACT] = fault_act ^ fprev_q[2];
		mask_d = mask_q;
		map_d = map_q;
		st_d = st_q;
		rdata_d = '0;
		if (reg_wr_in) begin
			case (reg_addr_in)
				`TSPT_REG_MASK: mask_d = reg_wdata_in[`TSPT_ST_W-1:0];
				`TSPT_REG_MAP: map_d = reg_wdata_in; // RULE12
				default: begin
				end
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				`TSPT_REG_STATUS: begin
					rdata_d = {{(32-`TSPT_ST_W){1'b0}}, st_q};
					st_d = '0; // Read clears.
				end
				`TSPT_REG_MASK: rdata_d = {{(32-`TSPT_ST_W){1'b0}}, mask_q};
				`TSPT_REG_STATE: rdata_d = state_word;
				`TSPT_REG_MAP: rdata_d = map_q;
				default: rdata_d = '0; // Unmapped reads return zero.
			endcase
		end
		st_d = st_d | ev; // A new event beats a clearing read.
		irq_d = |(st_d & mask_d);
		fault_act_d = fault_act;
	end

	// All state registers but the synchroniser; the clock enable freezes everything at once.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sel_q <= TSPT_SEL_A;
			rx_q <= '0;
			cause_a_q <= 1'b0;
			cause_b_q <= 1'b0;
			cause_act_q <= 1'b0;
			pss_q <= 1'b0;
			pa_q <= '0;
			pb_q <= '0;
			ttx_q <= '0;
			map_q <= `TSPT_MAP_RESET;
			tun_q <= '0;
			tun_ck_q <= 1'b0;
			tun_fs_q <= 1'b0;
			tun_ssf_q <= 1'b1;
			st_q <= '0;
			mask_q <= '0;
			fprev_q <= '0;
			rdata_q <= '0;
			irq_q <= 1'b0;
			fault_act_q <= 1'b0;
		end else if (ce_in) begin
			sel_q <= sel_d;
			rx_q <= rx_d;
			cause_a_q <= cause_a_d;
			cause_b_q <= cause_b_d;
			cause_act_q <= cause_act_d;
			pss_q <= pss_d;
			pa_q <= pa_d;
			pb_q <= pb_d;
			ttx_q <= ttx_d;
			map_q <= map_d;
			tun_q <= tun_d;
			tun_ck_q <= tun_ck_d;
			tun_fs_q <= tun_fs_d;
			tun_ssf_q <= tun_ssf_d;
			st_q <= st_d;
			mask_q <= mask_d;
			fprev_q <= fprev_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
			fault_act_q <= fault_act_d;
		end
	end

	// Outputs, each straight from a register.
	assign {path_a_data_out, path_a_ck_out, path_a_fs_out, path_a_ssf_out} = pa_q;
	assign {path_b_data_out, path_b_ck_out, path_b_fs_out, path_b_ssf_out} = pb_q;
	assign {rx_data_out, rx_ck_out, rx_fs_out, adapted_trail_fail_out} = rx_q;
	assign {tun_tx_data_out, tun_tx_ck_out, tun_tx_fs_out, tun_tx_ssf_out} = ttx_q;
	assign sink_fail_cause_report_out = cause_act_q;
	assign sink_fail_fault_out = fault_act_q;
	assign protected_sink_fail_cause_report_a_out = cause_a_q;
	assign protected_sink_fail_cause_report_b_out = cause_b_q;
	assign protection_switch_state_report_out = pss_q;
	assign tun_ch_data_out = tun_q;
	assign tun_ch_ck_out = tun_ck_q;
	assign tun_ch_fs_out = tun_fs_q;
	assign tun_ch_ssf_out = tun_ssf_q;
	assign reg_rdata_out = rdata_q;
	assign irq_out = irq_q;

	// Both transmit paths always carry identical content.
	AST_TX_DUP: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE2
		pa_q == pb_q)
		else $error("Transmit paths differ.");
	// Active A fails while B is healthy: B is active next cycle.
	AST_SWITCH_OVER: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE6
		ce_in && sel_q == TSPT_SEL_A && a_ssf && !b_ssf |=> sel_q == TSPT_SEL_B)
		else $error("No switch to the healthy side.");
	// Both failing: the choice holds.
	AST_BOTH_FAIL_HOLD: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE7
		ce_in && a_ssf && b_ssf |=> $stable(sel_q))
		else $error("Switched while both sides fail.");
	// A change of side only ever follows a failing active side; the reset return to A is exempt.
	AST_HEALTHY_KEPT: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE4
		!$past(rst_in) && sel_q != $past(sel_q) |-> $past(act_ssf))
		else $error("Left a healthy active side.");
	// Received bundle follows the active side one cycle later.
	AST_ROUTE_ACTIVE: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE8
		ce_in |=> rx_q == ($past(sel_q) == TSPT_SEL_B ? $past(rxb_s) : $past(rxa_s)))
		else $error("Inactive side routed onward.");
	// The management output names the side in use.
	AST_PSS_MATCH: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE9
		pss_q == (sel_q == TSPT_SEL_B))
		else $error("Switch state report wrong.");
	// Trail fail action tracks the active server fail one cycle later.
	AST_TSF_FOLLOW: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE16
		ce_in ##1 ce_in |-> adapted_trail_fail_out == $past(act_ssf) && 
		sink_fail_cause_report_out == $past(act_ssf))
		else $error("Trail fail or cause not following server fail.");
	// Without a valid map the tunnel lanes flag failure.
	AST_MAP_IDLE: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE12
		ce_in && !map_q[`TSPT_MAP_VALID] |=> tun_ch_ssf_out && tun_ch_data_out == '0)
		else $error("Tunnel lanes live without a map.");
	COV_TO_B: cover property (@(posedge sys_clk_in) disable iff (rst_in)
		sel_q == TSPT_SEL_A ##1 sel_q == TSPT_SEL_B);
	COV_TO_A: cover property (@(posedge sys_clk_in) disable iff (rst_in)
		sel_q == TSPT_SEL_B ##1 sel_q == TSPT_SEL_A);
	COV_IRQ: cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(irq_q));
endmodule

// file: verification/test_ts_protection_trail_term.sv
// Self-checking bench for the slot protection switch and trail terminations.
// Assumes two channel models on the receive side and a plain register port.
`timescale 1ns/100ps
`include "tspt_defines.svh"
module test_ts_protection_trail_term;
	import tspt_pkg::*;
	logic sys_clk_in, rst_in, ce_in, reg_wr_in, reg_rd_in, irq_out;
	tspt_addr_t reg_addr_in;
	tspt_word_t reg_wdata_in, reg_rdata_out;
	logic [7:0] tx_data_in, path_a_data_out, path_b_data_out, rx_a_data_in, rx_b_data_in;
	logic tx_ck_in, tx_fs_in, tx_trail_fail_in, path_a_ck_out, path_a_fs_out, path_a_ssf_out;
	logic path_b_ck_out, path_b_fs_out, path_b_ssf_out, rx_a_ck_in, rx_a_fs_in, rx_b_ck_in;
	logic rx_b_fs_in, rx_a_server_signal_fail_in, rx_b_server_signal_fail_in;
	logic [7:0] rx_data_out, tun_tx_data_in, tun_tx_data_out, word_a, word_b;
	logic rx_ck_out, rx_fs_out, adapted_trail_fail_out, sink_fail_cause_report_out;
	logic sink_fail_fault_out, protected_sink_fail_cause_report_a_out;
	logic protected_sink_fail_cause_report_b_out, protection_switch_state_report_out;
	logic tun_tx_ck_in, tun_tx_fs_in, tun_tx_trail_fail_in, tun_tx_ck_out, tun_tx_fs_out;
	logic tun_tx_ssf_out, tun_rx_ck_in, tun_rx_fs_in, tun_rx_server_signal_fail_in;
	logic [31:0] tun_rx_data_in, tun_ch_data_out;
	logic tun_ch_ck_out, tun_ch_fs_out, tun_ch_ssf_out, fail_a, fail_b;
	int fails = 0;
	int n_compared = 0;
	// Rows: {fail A, fail B, expected side, expected trail fail, switch event}.
	logic [4:0] rows [5] = '{5'b00000, 5'b10101, 5'b00100, 5'b11110, 5'b01001};
	// Link clock and frame start of sides A and B on the last three edges, {A ck, A fs, B ck, B fs}.
	// The oldest entry is what the pass-through outputs must show, three edges on.
	logic [3:0] lk_hist [3];
	always @(posedge sys_clk_in) begin
		lk_hist[0] <= {rx_a_ck_in, rx_a_fs_in, rx_b_ck_in, rx_b_fs_in};
		lk_hist[1] <= lk_hist[0];
		lk_hist[2] <= lk_hist[1];
	end

	// Transmit and tunnel receive clocks borrow the link clock of side A, tunnel transmit that of side B.
	assign tx_ck_in = rx_a_ck_in;
	assign tx_fs_in = rx_a_fs_in;
	assign tun_tx_ck_in = rx_b_ck_in;
	assign tun_tx_fs_in = rx_b_fs_in;
	assign tun_rx_ck_in = rx_a_ck_in;
	assign tun_rx_fs_in = rx_a_fs_in;

	// Short fault counts keep the run brief; checks below derive from them.
	tspt_top #(.FAULT_SET_CYC(20), .FAULT_CLR_CYC(80)) i_dut (.sys_clk_in, .rst_in, .ce_in,
		.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out,
		.tx_data_in, .tx_ck_in, .tx_fs_in, .tx_trail_fail_in, .path_a_data_out, .path_a_ck_out,
		.path_a_fs_out, .path_a_ssf_out, .path_b_data_out, .path_b_ck_out, .path_b_fs_out,
		.path_b_ssf_out, .rx_a_data_in, .rx_a_ck_in, .rx_a_fs_in, .rx_a_server_signal_fail_in,
		.rx_b_data_in, .rx_b_ck_in, .rx_b_fs_in, .rx_b_server_signal_fail_in, .rx_data_out,
		.rx_ck_out, .rx_fs_out, .adapted_trail_fail_out, .sink_fail_cause_report_out,
		.sink_fail_fault_out, .protected_sink_fail_cause_report_a_out,
		.protected_sink_fail_cause_report_b_out, .protection_switch_state_report_out,
		.tun_tx_data_in, .tun_tx_ck_in, .tun_tx_fs_in, .tun_tx_trail_fail_in, .tun_tx_data_out,
		.tun_tx_ck_out, .tun_tx_fs_out, .tun_tx_ssf_out, .tun_rx_data_in, .tun_rx_ck_in,
		.tun_rx_fs_in, .tun_rx_server_signal_fail_in, .tun_ch_data_out, .tun_ch_ck_out,
		.tun_ch_fs_out, .tun_ch_ssf_out);
	// Two neighbours with different phases for interfaces A and B.
	tspt_chan_model #(.PH(130)) i_side_a (.word_in(word_a), .fail_in(fail_a),
		.data_out(rx_a_data_in), .ck_out(rx_a_ck_in), .fs_out(rx_a_fs_in),
		.ssf_out(rx_a_server_signal_fail_in));
	tspt_chan_model #(.PH(370)) i_side_b (.word_in(word_b), .fail_in(fail_b),
		.data_out(rx_b_data_in), .ck_out(rx_b_ck_in), .fs_out(rx_b_fs_in),
		.ssf_out(rx_b_server_signal_fail_in));

	// System clock of 100 ns.
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	// Compares one value and counts it.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	// One write cycle on the register port.
	task automatic wr(input tspt_addr_t a, input tspt_word_t d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// One read cycle; the data are taken in the cycle after the strobe only.
	task automatic rd_chk(input tspt_addr_t a, input tspt_word_t m, input tspt_word_t e);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		@(posedge sys_clk_in);
		chk(reg_rdata_out & m, e);
	endtask
	task automatic end_sim;
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// The whole sequence needs well under two thousand cycles.
	initial begin
		wait_clk(5000);
		fails++;
		end_sim();
	end

	initial begin
		{rst_in, ce_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = {2'b11, 42'h0};
		{tx_data_in, tx_trail_fail_in, tun_tx_data_in, tun_tx_trail_fail_in} = 18'h0;
		{tun_rx_data_in, tun_rx_server_signal_fail_in} = 33'h0;
		{word_a, word_b, fail_a, fail_b} = 18'h0;
		wait_clk(8);
		rst_in <= 1'b0;
		wr(`TSPT_REG_MASK, 32'h0000_0001);
		wait_clk(4);
		chk({tun_ch_data_out[30:0], tun_ch_ssf_out}, 32'h0000_0001);
		// Ordinary switch cases, one row at a time.
		foreach (rows[i]) begin
			{fail_a, fail_b} <= rows[i][4:3];
			word_a <= 8'h10 + 8'(i);
			word_b <= 8'h80 + 8'(i);
			wait_clk(14);
			chk(protection_switch_state_report_out, rows[i][2]);
			chk(rx_data_out, rows[i][2] ? 8'h80 + 8'(i) : 8'h10 + 8'(i));
			chk(adapted_trail_fail_out, rows[i][1]);
			chk(sink_fail_cause_report_out, rows[i][1]);
			chk({protected_sink_fail_cause_report_a_out,
				protected_sink_fail_cause_report_b_out}, rows[i][4:3]);
			chk(irq_out, rows[i][0]);
			chk({rx_ck_out, rx_fs_out, path_a_ck_out, path_a_fs_out, path_b_ck_out, path_b_fs_out,
				tun_tx_ck_out, tun_tx_fs_out, tun_ch_ck_out, tun_ch_fs_out},
				{rows[i][2] ? lk_hist[2][1:0] : lk_hist[2][3:2], {2{lk_hist[2][3:2]}},
				lk_hist[2][1:0], lk_hist[2][3:2]});
			rd_chk(`TSPT_REG_STATE, 32'h0000_0001, rows[i][2]);
			rd_chk(`TSPT_REG_STATUS, 32'h0000_0001, rows[i][0]);
		end
		// Let every fault integrator clear first, since the rows leave faults set.
		{fail_a, fail_b} <= 2'b00;
		wait_clk(90);
		// Both sides failing: A stays active and its fault integrates.
		{fail_a, fail_b} <= 2'b11;
		wait_clk(21);
		chk(sink_fail_fault_out, 1'b0);
		wait_clk(6);
		chk({sink_fail_fault_out, protection_switch_state_report_out}, 2'b10);
		rd_chk(`TSPT_REG_STATE, 32'h0000_007F, 32'h0000_007E);
		fail_a <= 1'b0;
		wait_clk(81);
		chk(sink_fail_fault_out, 1'b1);
		wait_clk(6);
		chk(sink_fail_fault_out, 1'b0);
		// Tunnel receive with a reversing map, then a failed tunnel.
		tun_rx_data_in <= 32'h4433_2211;
		wr(`TSPT_REG_MAP, 32'h8000_001B);
		wait_clk(6);
		chk(tun_ch_data_out, 32'h1122_3344);
		chk(tun_ch_ssf_out, 1'b0);
		rd_chk(`TSPT_REG_MAP, 32'hFFFF_FFFF, 32'h8000_001B);
		tun_rx_server_signal_fail_in <= 1'b1;
		wait_clk(6);
		chk(tun_ch_ssf_out, 1'b1);
		// Transmit duplication and tunnel source pass-through.
		{tx_data_in, tx_trail_fail_in, tun_tx_data_in, tun_tx_trail_fail_in} <= 18'h2_96B5;
		wait_clk(6);
		chk({path_a_data_out, path_b_data_out, path_a_ssf_out, path_b_ssf_out},
			{8'hA5, 8'hA5, 2'b11});
		chk({tun_tx_data_out, tun_tx_ssf_out}, {8'h5A, 1'b1});
		// Unmapped place reads zero and keeps no write.
		wr(8'h10, 32'hFFFF_FFFF);
		rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
		// Masked switch: status records it, the interrupt stays low.
		wr(`TSPT_REG_MASK, 32'h0000_0000);
		fail_a <= 1'b1;
		fail_b <= 1'b0;
		wait_clk(14);
		chk({irq_out, protection_switch_state_report_out}, 2'b01);
		rd_chk(`TSPT_REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		// Reset in mid-run returns side A and clears the map.
		rst_in <= 1'b1;
		wait_clk(2);
		rst_in <= 1'b0;
		wait_clk(1);
		chk({protection_switch_state_report_out, tun_ch_ssf_out}, 2'b01);
		rd_chk(`TSPT_REG_MAP, 32'hFFFF_FFFF, 32'h0000_0000);
		wait_clk(14);
		chk(protection_switch_state_report_out, 1'b1);
		// Clock enable low freezes the switch although side B now fails.
		ce_in <= 1'b0;
		{fail_a, fail_b} <= 2'b01;
		wait_clk(14);
		chk(protection_switch_state_report_out, 1'b1);
		ce_in <= 1'b1;
		wait_clk(14);
		chk(protection_switch_state_report_out, 1'b0);
		end_sim();
	end
endmodule

// file: verification/tspt_chan_model.sv
// Model of one received slot channel as the neighbouring function presents it.
// Assumes the bench sets the slot word and the fail flag; the link clock runs free.
`timescale 1ns/100ps
module tspt_chan_model #(
	parameter int DATA_W = 8,
	parameter int PH = 130
) (
	input wire logic [DATA_W-1:0] word_in,
	input wire logic fail_in,
	output logic [DATA_W-1:0] data_out,
	output logic ck_out,
	output logic fs_out,
	output logic ssf_out
);
	// Slot position inside a frame of eight link clocks.
	logic [2:0] slot_q;
	// The link clock gets its own phase so each instance meets the sampler at one fixed alignment of its own.
	initial begin
		ck_out = 1'b0;
		#PH;
		forever #400 ck_out = ~ck_out;
	end
	// Data and frame start move only on link clock edges, like a real neighbour.
	initial begin
		slot_q = 3'h0;
		data_out = '0;
		fs_out = 1'b0;
		forever begin
			@(posedge ck_out);
			slot_q = slot_q + 3'h1;
			fs_out = (slot_q == 3'h0);
			data_out = word_in;
		end
	end
	// The fail flag is a level and is passed on at once.
	assign ssf_out = fail_in;
endmodule
